// ===== rxf_filter_match.sv
// one filter row: pattern, vlan and mpls terms anded together
module rxf_filter_match
   import rxf_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   rxf_frame_if.dst frm,
   input wire logic [31:0] ctrl,
   input wire logic [31:0] pattern,
   input wire logic [31:0] patMask,
   input wire logic [7:0][31:0] vlanCfg,
   input wire logic [7:0][31:0] mplsVal,
   input wire logic [7:0][31:0] mplsMask,
   output logic match
);
   logic [3:0] vLvl;
   logic [3:0] mLvl;
   logic [31:0] pm;
   logic [15:0] vm;
   logic [31:0] mm;
   logic patOk;
   logic vlanOk;
   logic mplsOk;

   always_comb
   begin
      vLvl = (ctrl[RXF_C_VLVL +: 4] > RXF_LVL_MAX) ? RXF_LVL_MAX
         : ctrl[RXF_C_VLVL +: 4];
      mLvl = (ctrl[RXF_C_MLVL +: 4] > RXF_LVL_MAX) ? RXF_LVL_MAX
         : ctrl[RXF_C_MLVL +: 4];
      pm = ctrl[RXF_C_PATMASK] ? patMask : 32'hFFFFFFFF;
      patOk = 1'b1;
      if (ctrl[RXF_C_PATSEL])
      begin
         patOk = frm.patValid && (((frm.patWord ^ pattern) & pm) == '0);
      end
      vlanOk = 1'b1;
      mplsOk = 1'b1;
      vm = '0;
      mm = '0;
      for (int l = 0; l < RXF_NLVL; l++)
      begin
         vm = RXF_VLAN_BASE | (ctrl[RXF_C_CFISEL] ? RXF_VLAN_CFI : 16'h0);
         if (ctrl[RXF_C_VMASK])
         begin
            vm = vm & vlanCfg[l][31:16];
         end
         if (4'(l) < vLvl)
         begin
            if (frm.vlanCnt <= 4'(l) ||
               ((frm.vlanTci[l] ^ vlanCfg[l][15:0]) & vm) != '0)
            begin
               vlanOk = 1'b0;
            end
         end
         mm = RXF_MPLS_BASE | (ctrl[RXF_C_EXPSEL] ? RXF_MPLS_EXP : '0)
            | (ctrl[RXF_C_BOSSEL] ? RXF_MPLS_BOS : '0);
         if (ctrl[RXF_C_MMASK])
         begin
            mm = mm & mplsMask[l];
         end
         if (4'(l) < mLvl)
         begin
            if (frm.mplsCnt <= 4'(l) ||
               ((frm.mplsEntry[l] ^ mplsVal[l]) & mm) != '0)
            begin
               mplsOk = 1'b0;
            end
         end
      end
      match = ctrl[RXF_C_EN] && patOk && vlanOk && mplsOk;
   end

   chk_filter_disabled: assert property (
      @(posedge clock) disable iff (srst) !ctrl[RXF_C_EN] |-> !match)
      else $error("disabled filter reports a match");
   chk_pattern_short: assert property (
      @(posedge clock) disable iff (srst)
      ctrl[RXF_C_EN] && ctrl[RXF_C_PATSEL] && !frm.patValid |-> !match)
      else $error("match without four pattern bytes");
   chk_pattern_exact: assert property (
      @(posedge clock) disable iff (srst)
      match && ctrl[RXF_C_PATSEL] && !ctrl[RXF_C_PATMASK]
      |-> frm.patWord == pattern)
      else $error("unmasked pattern match with unequal word");
endmodule : rxf_filter_match

// ===== rxf_frame_filter.sv
// receive frame filter: header parser, eight filters, axi4-lite registers
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
module rxf_frame_filter
   import rxf_pkg::*;
(
   input wire logic clock,
   input wire logic srst,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxLast,
   output logic decValid,
   output logic decPass,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [11:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   logic [31:0] fCtrl_r [RXF_NFLT];
   logic [31:0] fPat_r [RXF_NFLT];
   logic [31:0] fPatMask_r [RXF_NFLT];
   logic [7:0][31:0] fVlan_r [RXF_NFLT];
   logic [7:0][31:0] fMval_r [RXF_NFLT];
   logic [7:0][31:0] fMmask_r [RXF_NFLT];
   logic [31:0] gCtrl_r;
   logic [15:0] patOffset_r;
   logic [31:0] passCnt_r;
   logic [31:0] frameCnt_r;
   logic [11:0] awAddr_r;
   logic awHeld_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic wHeld_r;
   logic doWrite;
   rxf_hdr_t hdr_r;
   logic [15:0] byteCnt_r;
   logic [1:0] fldIdx_r;
   logic [31:0] acc_r;
   logic [31:0] accNxt;
   logic [31:0] patWord_r;
   logic [2:0] patCnt_r;
   logic [7:0][15:0] vlanTci_r;
   logic [3:0] vlanCnt_r;
   logic [7:0][31:0] mplsEntry_r;
   logic [3:0] mplsCnt_r;
   logic encEth_r;
   logic encSnap_r;
   logic encLlc_r;
   logic evalPending_r;
   logic [16:0] patDiff;
   logic inWin;
   logic [RXF_NFLT-1:0] fMatch;
   logic [RXF_NFLT-1:0] enVec;
   logic [2:0] encSel;
   logic encOk;
   logic anyHit;

   rxf_frame_if frm ();
   assign frm.patWord = patWord_r;
   assign frm.patValid = (patCnt_r == RXF_PAT_BYTES);
   assign frm.vlanTci = vlanTci_r;
   assign frm.vlanCnt = vlanCnt_r;
   assign frm.mplsEntry = mplsEntry_r;
   assign frm.mplsCnt = mplsCnt_r;

   // register write path
   assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
   assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
   assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   function automatic logic mapped(input logic [11:0] a);
      logic ok;
      ok = 1'b0;
      if (a[1:0] != 2'b00)
      begin
         ok = 1'b0;
      end
      else if (!a[11])
      begin
         ok = (a[7:0] <= RXF_F_PMASK) ||
            (a[7:0] >= RXF_F_VLAN && a[7:0] <= RXF_F_MMASK_END);
      end
      else
      begin
         ok = (a <= RXF_G_FRAMECNT);
      end
      return ok;
   endfunction : mapped

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         awAddr_r <= '0;
         wData_r <= '0;
         wStrb_r <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RXF_RESP_OK;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(awAddr_r) ? RXF_RESP_OK : RXF_RESP_ERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration storage
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         gCtrl_r <= RXF_CTRL_RST;
         patOffset_r <= RXF_OFFSET_RST;
         for (int f = 0; f < RXF_NFLT; f++)
         begin
            fCtrl_r[f] <= RXF_CTRL_RST;
            fPat_r[f] <= '0;
            fPatMask_r[f] <= '0;
            fVlan_r[f] <= '0;
            fMval_r[f] <= '0;
            fMmask_r[f] <= '0;
         end
      end
      else if (doWrite && mapped(awAddr_r))
      begin
         if (awAddr_r == RXF_G_CTRL)
         begin
            gCtrl_r <= rxf_merge(gCtrl_r, wData_r, wStrb_r);
         end
         else if (awAddr_r == RXF_G_OFFSET)
         begin
            patOffset_r <= 16'(rxf_merge({16'h0, patOffset_r}, wData_r,
               wStrb_r));
         end
         else if (awAddr_r[7:0] == RXF_F_CTRL && !awAddr_r[11])
         begin
            fCtrl_r[awAddr_r[10:8]] <= rxf_merge(fCtrl_r[awAddr_r[10:8]],
               wData_r, wStrb_r);
         end
         else if (awAddr_r[7:0] == RXF_F_PAT && !awAddr_r[11])
         begin
            fPat_r[awAddr_r[10:8]] <= rxf_merge(fPat_r[awAddr_r[10:8]],
               wData_r, wStrb_r);
         end
         else if (awAddr_r[7:0] == RXF_F_PMASK && !awAddr_r[11])
         begin
            fPatMask_r[awAddr_r[10:8]] <= rxf_merge(
               fPatMask_r[awAddr_r[10:8]], wData_r, wStrb_r);
         end
         else if (awAddr_r[7:5] == RXF_F_VLAN[7:5] && !awAddr_r[11])
         begin
            fVlan_r[awAddr_r[10:8]][awAddr_r[4:2]] <= rxf_merge(
               fVlan_r[awAddr_r[10:8]][awAddr_r[4:2]], wData_r, wStrb_r);
         end
         else if (awAddr_r[7:5] == RXF_F_MVAL[7:5] && !awAddr_r[11])
         begin
            fMval_r[awAddr_r[10:8]][awAddr_r[4:2]] <= rxf_merge(
               fMval_r[awAddr_r[10:8]][awAddr_r[4:2]], wData_r, wStrb_r);
         end
         else if (awAddr_r[7:5] == RXF_F_MMASK[7:5] && !awAddr_r[11])
         begin
            fMmask_r[awAddr_r[10:8]][awAddr_r[4:2]] <= rxf_merge(
               fMmask_r[awAddr_r[10:8]][awAddr_r[4:2]], wData_r, wStrb_r);
         end
      end
   end

   // register read path, one cycle after the address is taken
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RXF_RESP_OK;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped(s_axi_araddr) ? RXF_RESP_OK : RXF_RESP_ERR;
         s_axi_rdata <= '0;
         if (!mapped(s_axi_araddr))
         begin
            s_axi_rdata <= '0;
         end
         else if (s_axi_araddr == RXF_G_CTRL)
         begin
            s_axi_rdata <= gCtrl_r;
         end
         else if (s_axi_araddr == RXF_G_OFFSET)
         begin
            s_axi_rdata <= {16'h0, patOffset_r};
         end
         else if (s_axi_araddr == RXF_G_STATUS)
         begin
            s_axi_rdata <= {21'h0, encLlc_r, encSnap_r, encEth_r,
               mplsCnt_r, vlanCnt_r};
         end
         else if (s_axi_araddr == RXF_G_PASSCNT)
         begin
            s_axi_rdata <= passCnt_r;
         end
         else if (s_axi_araddr == RXF_G_FRAMECNT)
         begin
            s_axi_rdata <= frameCnt_r;
         end
         else if (s_axi_araddr[7:0] == RXF_F_CTRL)
         begin
            s_axi_rdata <= fCtrl_r[s_axi_araddr[10:8]];
         end
         else if (s_axi_araddr[7:0] == RXF_F_PAT)
         begin
            s_axi_rdata <= fPat_r[s_axi_araddr[10:8]];
         end
         else if (s_axi_araddr[7:0] == RXF_F_PMASK)
         begin
            s_axi_rdata <= fPatMask_r[s_axi_araddr[10:8]];
         end
         else if (s_axi_araddr[7:5] == RXF_F_VLAN[7:5])
         begin
            s_axi_rdata <= fVlan_r[s_axi_araddr[10:8]][s_axi_araddr[4:2]];
         end
         else if (s_axi_araddr[7:5] == RXF_F_MVAL[7:5])
         begin
            s_axi_rdata <= fMval_r[s_axi_araddr[10:8]][s_axi_araddr[4:2]];
         end
         else
         begin
            s_axi_rdata <= fMmask_r[s_axi_araddr[10:8]][s_axi_araddr[4:2]];
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // header parser and pattern capture
   assign accNxt = {acc_r[23:0], rxData};
   assign patDiff = {1'b0, byteCnt_r} - {1'b0, patOffset_r};
   assign inWin = !patDiff[16] && patDiff[15:0] < 16'(RXF_PAT_BYTES);

   always_ff @(posedge clock)
   begin
      if (srst || evalPending_r)
      begin
         hdr_r <= RXF_H_MAC;
         byteCnt_r <= '0;
         fldIdx_r <= '0;
         acc_r <= '0;
         patWord_r <= '0;
         patCnt_r <= '0;
         vlanTci_r <= '0;
         vlanCnt_r <= '0;
         mplsEntry_r <= '0;
         mplsCnt_r <= '0;
         encEth_r <= 1'b0;
         encSnap_r <= 1'b0;
         encLlc_r <= 1'b0;
      end
      else if (rxValid)
      begin
         acc_r <= accNxt;
         fldIdx_r <= fldIdx_r + 2'd1;
         if (byteCnt_r != 16'hFFFF)
         begin
            byteCnt_r <= byteCnt_r + 16'd1;
         end
         if (inWin && patCnt_r != RXF_PAT_BYTES)
         begin
            patWord_r <= {patWord_r[23:0], rxData};
            patCnt_r <= patCnt_r + 3'd1;
         end
         case (hdr_r)
            RXF_H_MAC:
            begin
               fldIdx_r <= '0;
               if (byteCnt_r == RXF_LAST_MAC_BYTE)
               begin
                  hdr_r <= RXF_H_TYPE;
               end
            end
            RXF_H_TYPE:
            begin
               if (fldIdx_r == 2'd1)
               begin
                  fldIdx_r <= '0;
                  if (accNxt[15:0] == RXF_ET_VLAN ||
                     accNxt[15:0] == RXF_ET_QINQ)
                  begin
                     hdr_r <= RXF_H_VLAN;
                  end
                  else if (accNxt[15:0] == RXF_ET_MPLS ||
                     accNxt[15:0] == RXF_ET_MPLSM)
                  begin
                     hdr_r <= RXF_H_MPLS;
                     encEth_r <= 1'b1;
                  end
                  else if (accNxt[15:0] >= RXF_ET_MIN)
                  begin
                     hdr_r <= RXF_H_DONE;
                     encEth_r <= 1'b1;
                  end
                  else
                  begin
                     hdr_r <= RXF_H_LLC;
                  end
               end
            end
            RXF_H_VLAN:
            begin
               if (fldIdx_r == 2'd1)
               begin
                  fldIdx_r <= '0;
                  hdr_r <= RXF_H_TYPE;
                  if (vlanCnt_r != RXF_LVL_MAX)
                  begin
                     vlanTci_r[vlanCnt_r[2:0]] <= accNxt[15:0];
                     vlanCnt_r <= vlanCnt_r + 4'd1;
                  end
               end
            end
            RXF_H_MPLS:
            begin
               if (fldIdx_r == 2'd3)
               begin
                  if (mplsCnt_r != RXF_LVL_MAX)
                  begin
                     mplsEntry_r[mplsCnt_r[2:0]] <= accNxt;
                     mplsCnt_r <= mplsCnt_r + 4'd1;
                  end
                  if ((accNxt & RXF_MPLS_BOS) != '0)
                  begin
                     hdr_r <= RXF_H_DONE;
                  end
               end
            end
            RXF_H_LLC:
            begin
               if (fldIdx_r == 2'd2)
               begin
                  hdr_r <= RXF_H_DONE;
                  if (accNxt[23:0] == RXF_SNAP_HDR)
                  begin
                     encSnap_r <= 1'b1;
                  end
                  else
                  begin
                     encLlc_r <= 1'b1;
                  end
               end
            end
            default:
            begin
               fldIdx_r <= '0;
            end
         endcase
      end
   end

   // filters and the decision
   genvar g;
   generate
      for (g = 0; g < RXF_NFLT; g++)
      begin : gFlt
         assign enVec[g] = fCtrl_r[g][RXF_C_EN];
         rxf_filter_match uMatch (
            .clock(clock),
            .srst(srst),
            .frm(frm),
            .ctrl(fCtrl_r[g]),
            .pattern(fPat_r[g]),
            .patMask(fPatMask_r[g]),
            .vlanCfg(fVlan_r[g]),
            .mplsVal(fMval_r[g]),
            .mplsMask(fMmask_r[g]),
            .match(fMatch[g])
         );
      end
   endgenerate

   assign encSel = gCtrl_r[RXF_G_ENC +: 3];
   assign encOk = (encSel == 3'b000) ||
      ((encSel & {encLlc_r, encSnap_r, encEth_r}) != 3'b000);
   assign anyHit = |fMatch;

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         evalPending_r <= 1'b0;
         decValid <= 1'b0;
         decPass <= 1'b0;
         passCnt_r <= '0;
         frameCnt_r <= '0;
      end
      else
      begin
         evalPending_r <= rxValid && rxLast;
         decValid <= evalPending_r;
         if (evalPending_r)
         begin
            decPass <= encOk && (anyHit || !gCtrl_r[RXF_G_ON]);
            frameCnt_r <= frameCnt_r + 32'd1;
            if (encOk && (anyHit || !gCtrl_r[RXF_G_ON]))
            begin
               passCnt_r <= passCnt_r + 32'd1;
            end
         end
      end
   end

   chk_decision_timing: assert property (
      @(posedge clock) disable iff (srst)
      rxValid && rxLast |-> ##2 decValid)
      else $error("decision not two cycles after last byte");
   chk_pass_needs_hit: assert property (
      @(posedge clock) disable iff (srst)
      decValid && decPass && gCtrl_r[RXF_G_ON] |-> $past(anyHit))
      else $error("frame passed with no matching filter");
   chk_encaps_open: assert property (
      @(posedge clock) disable iff (srst)
      decValid && $past(encSel) == 3'b000 && !$past(gCtrl_r[RXF_G_ON])
      |-> decPass)
      else $error("open gate dropped a frame");
   chk_enable_gates: assert property (
      @(posedge clock) disable iff (srst) (fMatch & ~enVec) == '0)
      else $error("disabled filter matched");
   chk_pattern_capture: assert property (
      @(posedge clock) disable iff (srst || evalPending_r)
      rxValid && patCnt_r == 3'd3 && inWin
      |=> frm.patValid && patWord_r[7:0] == $past(rxData))
      else $error("pattern byte not captured at offset");
   chk_vlan_depth: assert property (
      @(posedge clock) disable iff (srst) vlanCnt_r <= RXF_LVL_MAX)
      else $error("vlan level count above eight");
   chk_mpls_store: assert property (
      @(posedge clock) disable iff (srst || evalPending_r)
      rxValid && hdr_r == RXF_H_MPLS && fldIdx_r == 2'd3 &&
      mplsCnt_r < RXF_LVL_MAX
      |=> mplsCnt_r == $past(mplsCnt_r) + 4'd1)
      else $error("mpls entry not stored");
endmodule : rxf_frame_filter

// ===== rxf_frame_filter_tb_top.sv
// testbench of the receive frame filter
module rxf_frame_filter_tb_top
   import rxf_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic awV = 1'b0;
   logic wV = 1'b0;
   logic arV = 1'b0;
   logic [11:0] ad = 12'h000;
   logic [31:0] wD = 32'h0000_0000;
   logic rxValid, rxLast, decValid, decPass, awR, wR, bV, arR, rV;
   logic [7:0] rxData;
   logic [1:0] bResp, rResp;
   logic [31:0] rD;
   logic [7:0] m[$];
   int errors = 0;
   int num_checks = 0;
   always #4 clock = ~clock;
   rxf_frame_src src (.clock(clock), .rxValid(rxValid), .rxData(rxData),
      .rxLast(rxLast));
   rxf_frame_filter uut (.clock(clock), .srst(srst), .rxValid(rxValid),
      .rxData(rxData), .rxLast(rxLast), .decValid(decValid),
      .decPass(decPass), .s_axi_awvalid(awV), .s_axi_awready(awR),
      .s_axi_awaddr(ad), .s_axi_wvalid(wV), .s_axi_wready(wR),
      .s_axi_wdata(wD), .s_axi_wstrb(4'hF), .s_axi_bvalid(bV),
      .s_axi_bready(1'b1), .s_axi_bresp(bResp), .s_axi_arvalid(arV),
      .s_axi_arready(arR), .s_axi_araddr(ad), .s_axi_rvalid(rV),
      .s_axi_rready(1'b1), .s_axi_rdata(rD), .s_axi_rresp(rResp));
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask : cmp
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] e);
      ad <= a;
      wD <= d;
      awV <= 1'b1;
      wV <= 1'b1;
      do
      begin
         @(posedge clock);
         if (awR) awV <= 1'b0;
         if (wR) wV <= 1'b0;
      end
      while (bV !== 1'b1);
      cmp(bResp, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input logic [1:0] r);
      ad <= a;
      arV <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arR) arV <= 1'b0;
      end
      while (rV !== 1'b1);
      cmp(rD, e);
      cmp(rResp, r);
   endtask : rd
   task automatic fr(input logic [7:0] f[$], input logic e);
      src.send(f);
      for (int n = 0; n < 8; n++)
      begin
         @(posedge clock);
         if (decValid === 1'b1) break;
      end
      cmp(decValid, 32'h1);
      cmp(decPass, e);
   endtask : fr
   task automatic t_regs;
      rd(RXF_G_CTRL, RXF_CTRL_RST, RXF_RESP_OK);
      rd(RXF_G_OFFSET, 32'h0, RXF_RESP_OK);
      rd(12'hFFC, 32'h0, RXF_RESP_ERR);
      wr(12'hFFC, 32'h1, RXF_RESP_ERR);
      fr({m, 8'h00, 8'h10, 8'h42, 8'h42, 8'h03}, 1'b1);
      rd(RXF_G_FRAMECNT, 32'h1, RXF_RESP_OK);
      rd(RXF_G_PASSCNT, 32'h1, RXF_RESP_OK);
   endtask : t_regs
   task automatic t_pattern;
      logic [7:0] p[$];
      p = {m, 8'h08, 8'h00, 8'h55, 8'h55};
      wr(RXF_G_CTRL, 32'h1, RXF_RESP_OK);
      wr(RXF_G_OFFSET, 32'h7, RXF_RESP_OK);
      wr(RXF_F_PAT, 32'h0708_090A, RXF_RESP_OK);
      wr(RXF_F_CTRL, 32'h3, RXF_RESP_OK);
      fr(p, 1'b1);
      wr(RXF_F_PAT, 32'h0708_090B, RXF_RESP_OK);
      fr(p, 1'b0);
      wr(RXF_F_PMASK, 32'hFFFF_FF00, RXF_RESP_OK);
      wr(RXF_F_CTRL, 32'h7, RXF_RESP_OK);
      fr(p, 1'b1);
      fr(m[0:9], 1'b0);
      wr(RXF_G_OFFSET, 32'h8, RXF_RESP_OK);
      fr(p, 1'b0);
      wr(12'h104, 32'h0809_0A0B, RXF_RESP_OK);
      wr(12'h100, 32'h3, RXF_RESP_OK);
      fr(p, 1'b1);
      wr(12'h100, 32'h2, RXF_RESP_OK);
      fr(p, 1'b0);
      wr(RXF_F_CTRL, 32'h0, RXF_RESP_OK);
      wr(12'h100, 32'h3, RXF_RESP_OK);
      fr(p, 1'b1);
   endtask : t_pattern
   task automatic t_vlan;
      wr(12'h100, 32'h101, RXF_RESP_OK);
      wr(12'h120, 32'h6005, RXF_RESP_OK);
      fr({m, 8'h81, 8'h00, 8'h60, 8'h05, 8'h08, 8'h00}, 1'b1);
      fr({m, 8'h81, 8'h00, 8'h60, 8'h06, 8'h08, 8'h00}, 1'b0);
      fr({m, 8'h88, 8'hA8, 8'h70, 8'h05, 8'h08, 8'h00}, 1'b1);
      wr(12'h100, 32'h111, RXF_RESP_OK);
      fr({m, 8'h88, 8'hA8, 8'h70, 8'h05, 8'h08, 8'h00}, 1'b0);
   endtask : t_vlan
   task automatic t_mpls;
      wr(12'h100, 32'h0, RXF_RESP_OK);
      wr(12'h200, 32'h1001, RXF_RESP_OK);
      wr(12'h240, 32'h0001_2140, RXF_RESP_OK);
      fr({m, 8'h88, 8'h47, 8'h00, 8'h01, 8'h21, 8'h40}, 1'b1);
      fr({m, 8'h88, 8'h47, 8'h00, 8'h01, 8'h21, 8'h41}, 1'b0);
      wr(12'h260, 32'hFFFF_FF00, RXF_RESP_OK);
      wr(12'h200, 32'h1021, RXF_RESP_OK);
      fr({m, 8'h88, 8'h47, 8'h00, 8'h01, 8'h21, 8'h41}, 1'b1);
      wr(12'h200, 32'h1041, RXF_RESP_OK);
      fr({m, 8'h88, 8'h48, 8'h00, 8'h01, 8'h20, 8'h40}, 1'b0);
      wr(RXF_G_CTRL, 32'h2, RXF_RESP_OK);
      fr({m, 8'h00, 8'h10, 8'h42, 8'h42, 8'h03}, 1'b0);
      wr(RXF_G_CTRL, 32'h4, RXF_RESP_OK);
      fr({m, 8'h00, 8'h10, 8'hAA, 8'hAA, 8'h03}, 1'b1);
   endtask : t_mpls
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   initial
   begin
      #100000;
      errors++;
      report_and_stop;
   end
   initial
   begin
      for (int i = 0; i < 12; i++)
         m.push_back(8'(i));
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      t_regs;
      t_pattern;
      t_vlan;
      t_mpls;
      report_and_stop;
   end
endmodule : rxf_frame_filter_tb_top

// ===== rxf_frame_if.sv
// parsed fields of the current frame, shared by all filter matchers
interface rxf_frame_if;
   logic [31:0] patWord;
   logic patValid;
   logic [7:0][15:0] vlanTci;
   logic [3:0] vlanCnt;
   logic [7:0][31:0] mplsEntry;
   logic [3:0] mplsCnt;
   modport src (output patWord, patValid, vlanTci, vlanCnt, mplsEntry,
      mplsCnt);
   modport dst (input patWord, patValid, vlanTci, vlanCnt, mplsEntry,
      mplsCnt);
endinterface : rxf_frame_if

// ===== rxf_frame_src.sv
// frame source model standing in for the receive datapath
module rxf_frame_src
   import rxf_pkg::*;
(
   input wire logic clock,
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxLast
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      rxValid = 1'b0;
      rxData = 8'h00;
      rxLast = 1'b0;
   end
   // bytes back to back, then idle with data inverted
   task automatic send(input logic [7:0] f[$]);
      for (int i = 0; i < f.size(); i++)
      begin
         rxValid <= 1'b1;
         rxData <= f[i];
         rxLast <= (i == f.size() - 1);
         @(posedge clock);
      end
      rxValid <= 1'b0;
      rxLast <= 1'b0;
      rxData <= ~f[f.size() - 1];
   endtask : send
endmodule : rxf_frame_src

// ===== rxf_pkg.sv
// constants, register map and types of the receive frame filter
package rxf_pkg;
   localparam int RXF_NFLT = 8;
   localparam int RXF_NLVL = 8;
   localparam int RXF_AW = 12;
   // per-filter window: address bits 10:8 pick the filter
   localparam logic [7:0] RXF_F_CTRL = 8'h00;
   localparam logic [7:0] RXF_F_PAT = 8'h04;
   localparam logic [7:0] RXF_F_PMASK = 8'h08;
   localparam logic [7:0] RXF_F_VLAN = 8'h20;
   localparam logic [7:0] RXF_F_VLAN_END = 8'h3C;
   localparam logic [7:0] RXF_F_MVAL = 8'h40;
   localparam logic [7:0] RXF_F_MVAL_END = 8'h5C;
   localparam logic [7:0] RXF_F_MMASK = 8'h60;
   localparam logic [7:0] RXF_F_MMASK_END = 8'h7C;
   // global registers
   localparam logic [11:0] RXF_G_CTRL = 12'h800;
   localparam logic [11:0] RXF_G_OFFSET = 12'h804;
   localparam logic [11:0] RXF_G_STATUS = 12'h808;
   localparam logic [11:0] RXF_G_PASSCNT = 12'h80C;
   localparam logic [11:0] RXF_G_FRAMECNT = 12'h810;
   // filter control fields
   localparam int RXF_C_EN = 0;
   localparam int RXF_C_PATSEL = 1;
   localparam int RXF_C_PATMASK = 2;
   localparam int RXF_C_VMASK = 3;
   localparam int RXF_C_CFISEL = 4;
   localparam int RXF_C_MMASK = 5;
   localparam int RXF_C_BOSSEL = 6;
   localparam int RXF_C_EXPSEL = 7;
   localparam int RXF_C_VLVL = 8;
   localparam int RXF_C_MLVL = 12;
   // global control fields
   localparam int RXF_G_ON = 0;
   localparam int RXF_G_ENC = 1;
   localparam logic [31:0] RXF_CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] RXF_OFFSET_RST = 16'h0000;
   // frame layout
   localparam logic [15:0] RXF_LAST_MAC_BYTE = 16'h000B;
   localparam logic [15:0] RXF_ET_VLAN = 16'h8100;
   localparam logic [15:0] RXF_ET_QINQ = 16'h88A8;
   localparam logic [15:0] RXF_ET_MPLS = 16'h8847;
   localparam logic [15:0] RXF_ET_MPLSM = 16'h8848;
   localparam logic [15:0] RXF_ET_MIN = 16'h0600;
   localparam logic [23:0] RXF_SNAP_HDR = 24'hAAAA03;
   localparam logic [15:0] RXF_VLAN_BASE = 16'hEFFF;
   localparam logic [15:0] RXF_VLAN_CFI = 16'h1000;
   localparam logic [31:0] RXF_MPLS_BASE = 32'hFFFFF0FF;
   localparam logic [31:0] RXF_MPLS_EXP = 32'h00000E00;
   localparam logic [31:0] RXF_MPLS_BOS = 32'h00000100;
   localparam logic [3:0] RXF_LVL_MAX = 4'h8;
   localparam logic [2:0] RXF_PAT_BYTES = 3'h4;
   localparam logic [1:0] RXF_RESP_OK = 2'h0;
   localparam logic [1:0] RXF_RESP_ERR = 2'h2;

   typedef enum logic [5:0] {
      RXF_H_MAC = 6'b000001,
      RXF_H_TYPE = 6'b000010,
      RXF_H_VLAN = 6'b000100,
      RXF_H_MPLS = 6'b001000,
      RXF_H_LLC = 6'b010000,
      RXF_H_DONE = 6'b100000
   } rxf_hdr_t;

   function automatic logic [31:0] rxf_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
         begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction : rxf_merge
endpackage : rxf_pkg
